// ### rtl/hspbc_pkg.sv
package hspbc_pkg;
	// register offsets on the serial port
	localparam logic [7:0] ADDR_CKS1_HI = 8'ha9;
	localparam logic [7:0] ADDR_CKS1_LO = 8'haa;
	localparam logic [7:0] ADDR_CKS2_HI = 8'hb8;
	localparam logic [7:0] ADDR_CKS2_LO = 8'hb9;
	localparam logic [7:0] ADDR_IDENT = 8'hc5;
	localparam logic [7:0] ADDR_STATUS = 8'hc6;
	localparam logic [7:0] ADDR_PROG = 8'hc8;
	localparam logic [7:0] ADDR_VERSION = 8'hc9;
	localparam logic [7:0] ADDR_MASK = 8'hce;
	localparam logic [7:0] CMD_GENERAL_RESET = 8'h01;
	// values and field positions
	localparam logic [15:0] LOCK_MARK = 16'hdead;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam int STATUS_PROG_BIT = 0;
	localparam int MASK_PROG_BIT = 0;
	// frame bit counts: last address bit, last data bit, frame full
	localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
	localparam logic [4:0] BIT_DATA_LAST = 5'h17;
	localparam logic [4:0] BIT_FRAME_END = 5'h18;
	// service period
	localparam int CLK_PERIOD_NS = 50;
	localparam int SERVICE_PERIOD_NS = 250000;
	localparam int SERVICE_CYCLES = SERVICE_PERIOD_NS / CLK_PERIOD_NS;
	// boot strap codes {high, low}
	localparam logic [1:0] BOOT_HOST_LOAD = 2'h3;
	localparam logic [1:0] BOOT_RESERVED = 2'h2;
	localparam logic [1:0] BOOT_EEPROM_LOAD = 2'h1;
	localparam logic [1:0] BOOT_NO_LOAD = 2'h0;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	typedef enum {BOOT_SAMPLE, IMAGE_LOAD, AWAIT_CODE, OPERATIONAL, LOCKED} hspbc_boot_t;

	typedef struct packed {
		logic [31:0] checksum_one;
		logic [31:0] checksum_two;
		logic [15:0] version;
	} hspbc_image_info_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] data;
	} hspbc_write_t;

	function automatic logic hspbc_is_read(input logic [7:0] a);
		return (a == ADDR_CKS1_HI) || (a == ADDR_CKS1_LO) || (a == ADDR_CKS2_HI)
			|| (a == ADDR_CKS2_LO) || (a == ADDR_IDENT) || (a == ADDR_STATUS)
			|| (a == ADDR_VERSION);
	endfunction

	function automatic logic hspbc_is_write(input logic [7:0] a);
		return (a == ADDR_PROG) || (a == ADDR_MASK);
	endfunction
endpackage

// ### rtl/hspbc_top.sv
`timescale 1ns/1ps
`default_nettype none
module hspbc_top
	import hspbc_pkg::*;
#(
	parameter int SERVICE_CYCLES_P = SERVICE_CYCLES,
	parameter logic [31:0] ACTIVATION_CODE = 32'h5a5a_c3c3, // arbitrary value
	parameter logic [15:0] PRODUCT_ID = 16'h0a5e // arbitrary value
)(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic chip_select_n_i,
	input wire logic serial_clk_i,
	input wire logic host_to_device_line_i,
	output logic device_to_host_o,
	output logic device_to_host_oe_o,
	output logic irq_o,
	output logic irq_oe_o,
	input wire logic boot_select_high_i,
	input wire logic boot_select_low_i,
	input wire logic load_done_i,
	input wire hspbc_image_info_t image_info_i,
	output logic load_request_o,
	output logic [1:0] boot_source_o,
	output logic operational_o
);
	localparam int SVC_W = $clog2(SERVICE_CYCLES_P);

	if (SERVICE_CYCLES_P < 2)
	begin : g_bad_period
		$error("service period must be at least two cycles");
	end

	logic [2:0] sclk_sync;
	logic [1:0] csn_sync;
	logic [1:0] sdi_sync;
	logic [1:0] strap_hi_sync;
	logic [1:0] strap_lo_sync;
	logic [4:0] bit_cnt;
	logic [15:0] in_shift;
	logic [7:0] addr;
	logic reading;
	logic [15:0] rd_shift;
	logic [SVC_W-1:0] svc_cnt;
	hspbc_write_t pend;
	logic pend_valid;
	logic reset_pend;
	hspbc_boot_t state;
	logic [1:0] settle;
	logic [1:0] strap;
	logic code_half;
	logic [15:0] code_high;
	logic [31:0] cks_one;
	logic [31:0] cks_two;
	logic [15:0] version;
	logic [15:0] ident;
	logic [15:0] mask;
	logic prog_event;

	// pin synchronisers; serial clock has a third stage for edges
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sclk_sync <= 3'h0;
			csn_sync <= 2'h3;
			sdi_sync <= 2'h0;
			strap_hi_sync <= 2'h0;
			strap_lo_sync <= 2'h0;
		end
		else
		begin
			sclk_sync <= {sclk_sync[1:0], serial_clk_i};
			csn_sync <= {csn_sync[0], chip_select_n_i};
			sdi_sync <= {sdi_sync[0], host_to_device_line_i};
			strap_hi_sync <= {strap_hi_sync[0], boot_select_high_i};
			strap_lo_sync <= {strap_lo_sync[0], boot_select_low_i};
		end
	end

	// frame decode, independent of clock idle level and byte gaps
	logic cs_active;
	logic sclk_rise;
	logic sclk_fall;
	logic take_bit;
	logic give_bit;
	logic [15:0] shifted;
	logic addr_done;
	logic data_done;
	logic cmd_reset;
	logic status_read;
	assign cs_active = ~csn_sync[1];
	assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
	assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
	assign take_bit = sclk_rise & cs_active & (bit_cnt != BIT_FRAME_END);
	assign give_bit = sclk_fall & cs_active & reading & (bit_cnt != BIT_FRAME_END);
	assign shifted = {in_shift[14:0], sdi_sync[1]};
	assign addr_done = take_bit & (bit_cnt == BIT_ADDR_LAST);
	assign data_done = take_bit & (bit_cnt == BIT_DATA_LAST) & ~reading
		& hspbc_is_write(addr);
	assign cmd_reset = addr_done & (shifted[7:0] == CMD_GENERAL_RESET);
	assign status_read = addr_done & (shifted[7:0] == ADDR_STATUS);

	// bit counter, restarted by each select, and input shifter
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			bit_cnt <= 5'h00;
			in_shift <= 16'h0000;
			addr <= 8'h00;
		end
		else
		begin
			if (!cs_active)
				bit_cnt <= 5'h00;
			else if (take_bit)
				bit_cnt <= bit_cnt + 5'h01;
			if (take_bit)
				in_shift <= shifted;
			if (addr_done)
				addr <= shifted[7:0];
		end
	end

	// read value selection by address
	logic [15:0] status_word;
	logic [15:0] read_mux;
	assign status_word = REG_RESET | (16'(operational_o) << STATUS_PROG_BIT);
	always_comb
	begin
		case (shifted[7:0])
			ADDR_CKS1_HI: read_mux = cks_one[31:16];
			ADDR_CKS1_LO: read_mux = cks_one[15:0];
			ADDR_CKS2_HI: read_mux = cks_two[31:16];
			ADDR_CKS2_LO: read_mux = cks_two[15:0];
			ADDR_IDENT: read_mux = ident;
			ADDR_STATUS: read_mux = status_word;
			ADDR_VERSION: read_mux = version;
			default: read_mux = REG_RESET;
		endcase
	end

	// read path: new bit after each falling edge, driver only when reading
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			reading <= 1'b0;
			rd_shift <= 16'h0000;
			device_to_host_o <= 1'b0;
			device_to_host_oe_o <= 1'b0;
		end
		else
		begin
			if (!cs_active)
				reading <= 1'b0;
			else if (addr_done)
				reading <= hspbc_is_read(shifted[7:0]);
			if (addr_done)
				rd_shift <= read_mux;
			else if (give_bit)
				rd_shift <= {rd_shift[14:0], 1'b0};
			if (give_bit)
				device_to_host_o <= rd_shift[15];
			if (!cs_active)
				device_to_host_oe_o <= 1'b0;
			else if (give_bit)
				device_to_host_oe_o <= 1'b1;
		end
	end

	// service period divider
	logic svc_tick;
	assign svc_tick = (svc_cnt == SVC_W'(SERVICE_CYCLES_P - 1));
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			svc_cnt <= '0;
		else if (svc_tick)
			svc_cnt <= '0;
		else
			svc_cnt <= svc_cnt + SVC_W'(1);
	end

	// pending write and reset, consumed at the tick; a new capture wins
	logic next_pend_valid;
	logic next_reset_pend;
	assign next_pend_valid = data_done | (pend_valid & ~svc_tick);
	assign next_reset_pend = cmd_reset | (reset_pend & ~svc_tick);
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pend <= '0;
			pend_valid <= 1'b0;
			reset_pend <= 1'b0;
		end
		else
		begin
			if (data_done)
				pend <= {addr, shifted};
			pend_valid <= next_pend_valid;
			reset_pend <= next_reset_pend;
		end
	end

	// boot sequence decode
	logic apply_write;
	logic apply_reset;
	logic prog_write;
	logic act_good;
	logic act_bad;
	logic sample_now;
	logic load_finish;
	logic [1:0] strap_now;
	assign apply_write = svc_tick & pend_valid & (state != LOCKED);
	assign apply_reset = svc_tick & reset_pend & (state != LOCKED);
	// a reset in the same tick wins over a code write
	assign prog_write = apply_write & (pend.addr == ADDR_PROG) & (state == AWAIT_CODE)
		& ~apply_reset;
	assign act_good = prog_write & code_half & ({code_high, pend.data} == ACTIVATION_CODE);
	assign act_bad = prog_write & code_half & ({code_high, pend.data} != ACTIVATION_CODE);
	assign strap_now = {strap_hi_sync[1], strap_lo_sync[1]};
	assign sample_now = (state == BOOT_SAMPLE) & (settle == STRAP_SETTLE) & ~apply_reset;
	assign load_finish = (state == IMAGE_LOAD) & load_done_i & (strap != BOOT_RESERVED)
		& ~apply_reset;

	// boot state machine
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state <= BOOT_SAMPLE;
			settle <= 2'h0;
			strap <= BOOT_NO_LOAD;
			code_half <= 1'b0;
			code_high <= 16'h0000;
		end
		else if (apply_reset)
		begin
			state <= BOOT_SAMPLE;
			settle <= 2'h0;
			code_half <= 1'b0;
		end
		else
		begin
			case (state)
				BOOT_SAMPLE:
				begin
					settle <= settle + 2'h1;
					if (sample_now)
					begin
						strap <= strap_now;
						state <= (strap_now == BOOT_NO_LOAD) ? AWAIT_CODE : IMAGE_LOAD;
					end
				end
				IMAGE_LOAD:
					if (load_finish)
						state <= AWAIT_CODE;
				AWAIT_CODE:
					if (prog_write)
					begin
						code_half <= ~code_half;
						code_high <= pend.data;
						if (act_good)
							state <= OPERATIONAL;
						else if (act_bad)
							state <= LOCKED;
					end
				default:
					state <= state;
			endcase
		end
	end

	// image information registers
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cks_one <= 32'h0000_0000;
			cks_two <= 32'h0000_0000;
			version <= REG_RESET;
			ident <= REG_RESET;
		end
		else if (apply_reset | act_good)
		begin
			cks_one <= 32'h0000_0000;
			cks_two <= 32'h0000_0000;
			version <= REG_RESET;
			ident <= REG_RESET;
		end
		else if (act_bad)
			cks_one[31:16] <= LOCK_MARK;
		else if ((sample_now & (strap_now == BOOT_NO_LOAD)) | load_finish)
		begin
			cks_one <= image_info_i.checksum_one;
			cks_two <= image_info_i.checksum_two;
			version <= image_info_i.version;
			ident <= PRODUCT_ID;
		end
	end

	// mask, event and interrupt pin
	logic next_prog_event;
	assign next_prog_event = act_good | (prog_event & ~status_read);
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			mask <= REG_RESET;
			prog_event <= 1'b0;
			irq_o <= 1'b0;
			irq_oe_o <= 1'b0;
		end
		else
		begin
			if (apply_reset)
				mask <= REG_RESET;
			else if (apply_write & (pend.addr == ADDR_MASK))
				mask <= pend.data;
			prog_event <= next_prog_event;
			irq_o <= 1'b0;
			irq_oe_o <= prog_event & mask[MASK_PROG_BIT];
		end
	end

	// status outputs
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			load_request_o <= 1'b0;
			boot_source_o <= BOOT_NO_LOAD;
			operational_o <= 1'b0;
		end
		else
		begin
			load_request_o <= (state == IMAGE_LOAD) & (strap != BOOT_RESERVED);
			boot_source_o <= strap;
			operational_o <= (state == OPERATIONAL);
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_code_ok;
		act_good;
	endsequence
	sequence s_code_bad;
		act_bad;
	endsequence

	chk_mask_on_tick: assert property ($changed(mask) |-> $past(svc_tick))
		else $error("mask changed outside service tick");
	chk_tick_spacing: assert property (svc_tick |=> !svc_tick && svc_cnt == SVC_W'(0)
		##1 svc_cnt == SVC_W'(1))
		else $error("service tick spacing wrong");
	chk_irq_masked: assert property (irq_oe_o |-> $past(mask[MASK_PROG_BIT]) && $past(prog_event))
		else $error("interrupt without mask bit");
	chk_sample_rise: assert property (take_bit |=> in_shift[0] == $past(sdi_sync[1]))
		else $error("host bit not captured on rise");
	chk_read_hold: assert property ($changed(device_to_host_o) |-> $past(sclk_fall))
		else $error("read bit moved outside falling edge");
	chk_driver_off: assert property (!cs_active |=> !device_to_host_oe_o)
		else $error("read driver on without select");
	chk_activate_ok: assert property (s_code_ok |=> ##1 operational_o && cks_one == 32'h0)
		else $error("good code did not activate and clear");
	chk_dead_lock: assert property (s_code_bad |=> state == LOCKED
		&& cks_one[31:16] == LOCK_MARK ##1 state == LOCKED [*8])
		else $error("bad code did not lock");
	chk_locked_stays: assert property (state == LOCKED |=> state == LOCKED)
		else $error("locked state left");
	chk_straps_once: assert property ($changed(strap) |-> $past(state) == BOOT_SAMPLE)
		else $error("straps sampled outside boot");
endmodule
`default_nettype wire

// ### sim/hspbc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host controller acting as serial bus master
module hspbc_host
(
	input wire logic core_clk_i,
	input wire logic rd_line_i,
	input wire logic rd_oe_i,
	output logic chip_select_n_o,
	output logic serial_clk_o,
	output logic host_to_device_line_o,
	output logic oe_seen_o
);
	// half period of the link clock in core clocks
	localparam int HALF = 4;
	// idle levels at time zero
	initial
	begin
		chip_select_n_o = 1'b1;
		serial_clk_o = 1'b0;
		host_to_device_line_o = 1'b0;
		oe_seen_o = 1'b0;
	end
	task automatic idle(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	// one framed transfer; the link clock only runs inside the frame
	task automatic xfer(input logic [7:0] a, input int nbits, input logic [15:0] wd,
		input logic idle_hi, input logic gap, output logic [15:0] rd);
		logic [23:0] sh;
		sh = {a, wd};
		rd = 16'h0000;
		oe_seen_o = 1'b0;
		serial_clk_o = idle_hi;
		idle(HALF);
		chip_select_n_o = 1'b0;
		idle(HALF);
		for (int i = 0; i < nbits; i++)
		begin
			if (gap && i > 0 && i % 8 == 0)
				idle(9);
			serial_clk_o = 1'b0;
			host_to_device_line_o = sh[23 - i];
			idle(HALF);
			serial_clk_o = 1'b1;
			idle(HALF - 1);
			oe_seen_o = oe_seen_o | rd_oe_i;
			if (i >= 8)
				rd = {rd[14:0], rd_line_i};
			idle(1);
		end
		serial_clk_o = idle_hi;
		idle(HALF);
		chip_select_n_o = 1'b1;
		host_to_device_line_o = ~host_to_device_line_o;
		idle(10);
	endtask
endmodule
`default_nettype wire

// ### sim/host_serial_port_boot_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module host_serial_port_boot_control_bench;
	import hspbc_pkg::*;
	localparam int SVC = 400;
	localparam logic [31:0] CODE = 32'h5a5a_c3c3; // arbitrary value
	localparam logic [15:0] PID = 16'h0a5e; // arbitrary value
	localparam hspbc_image_info_t INFO = {32'h1234_5678, 32'h9abc_def0, 16'h0105};
	typedef struct packed {logic [7:0] a; logic [15:0] e; logic hi; logic gap;} hspbc_row_t;
	logic clk, rstn, chip_select_n, sclk, mosi, dout, doe, irq, irqoe, bhi, blo, ldone, lreq, oper, seen;
	logic [1:0] bsrc;
	logic [15:0] v;
	hspbc_image_info_t info;
	hspbc_row_t rows [7];
	int bad_count = 0;
	int tests_run = 0;
	int cycles = 0;
	// resolved read line and open-drain interrupt line with pull-up
	wire logic miso = doe ? dout : 1'bz;
	wire logic irq_n = irqoe ? irq : 1'b1;
	hspbc_top #(.SERVICE_CYCLES_P(SVC), .ACTIVATION_CODE(CODE), .PRODUCT_ID(PID)) hspbc_top_i (
		.core_clk_i(clk), .resetn_i(rstn), .chip_select_n_i(chip_select_n), .serial_clk_i(sclk),
		.host_to_device_line_i(mosi), .device_to_host_o(dout), .device_to_host_oe_o(doe),
		.irq_o(irq), .irq_oe_o(irqoe), .boot_select_high_i(bhi), .boot_select_low_i(blo),
		.load_done_i(ldone), .image_info_i(info), .load_request_o(lreq),
		.boot_source_o(bsrc), .operational_o(oper));
	hspbc_host hspbc_host_i (.core_clk_i(clk), .rd_line_i(miso), .rd_oe_i(doe),
		.chip_select_n_o(chip_select_n), .serial_clk_o(sclk), .host_to_device_line_o(mosi),
		.oe_seen_o(seen));
	// core clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", name, e, g);
			bad_count++;
		end
	endtask
	task automatic tick();
		repeat (SVC + 40) @(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		hspbc_host_i.xfer(a, 24, 16'h0000, 1'b0, 1'b0, v);
	endtask
	// write, then let a full service period pass before anything else
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		hspbc_host_i.xfer(a, 24, d, 1'b0, 1'b0, v);
		chk("oe during write", 16'h0000, {15'h0000, seen});
		tick();
	endtask
	task automatic gen_reset(input logic [1:0] s);
		{bhi, blo} = s;
		hspbc_host_i.xfer(CMD_GENERAL_RESET, 8, 16'h0000, 1'b0, 1'b0, v);
		tick();
	endtask
	initial
	begin
		rstn = 1'b0;
		{bhi, blo} = BOOT_HOST_LOAD;
		ldone = 1'b0;
		info = INFO;
		rows = '{'{ADDR_CKS1_HI, 16'h1234, 1'b0, 1'b0}, '{ADDR_CKS1_LO, 16'h5678, 1'b1, 1'b0},
			'{ADDR_CKS2_HI, 16'h9abc, 1'b0, 1'b1}, '{ADDR_CKS2_LO, 16'hdef0, 1'b1, 1'b1},
			'{ADDR_IDENT, PID, 1'b0, 1'b0}, '{ADDR_VERSION, 16'h0105, 1'b1, 1'b0},
			'{ADDR_STATUS, 16'h0000, 1'b0, 1'b1}};
		repeat (16) @(negedge clk);
		chk("outputs in reset", 16'h0000, {10'h000, doe, irqoe, lreq, oper, bsrc});
		rstn = 1'b1;
		repeat (10) @(negedge clk);
		chk("host load", 16'h0007, {13'h0000, lreq, bsrc});
		ldone = 1'b1;
		@(negedge clk);
		ldone = 1'b0;
		{bhi, blo} = BOOT_EEPROM_LOAD;
		repeat (10) @(negedge clk);
		chk("straps after load", 16'h0003, {13'h0000, lreq, bsrc});
		// reports after load, both clock idle levels, with and without gaps
		foreach (rows[i])
		begin
			hspbc_host_i.xfer(rows[i].a, 24, 16'h0000, rows[i].hi, rows[i].gap, v);
			chk("read data", rows[i].e, v);
			chk("oe after frame", 16'h0000, {15'h0000, doe});
		end
		wr(ADDR_MASK, 16'h0001);
		wr(ADDR_PROG, CODE[31:16]);
		chk("not yet active", 16'h0000, {15'h0000, oper});
		wr(ADDR_PROG, CODE[15:0]);
		chk("active", 16'h0001, {15'h0000, oper});
		chk("irq low", 16'h0000, {15'h0000, irq_n});
		rd(ADDR_STATUS);
		chk("status", 16'h0001, v);
		chk("irq released", 16'h0001, {15'h0000, irq_n});
		rd(ADDR_CKS1_HI);
		chk("cleared", 16'h0000, v);
		// general reset through every non-host strap code
		for (int s = 2; s >= 0; s--)
		begin
			gen_reset(s[1:0]);
			chk("strap decode", {13'h0000, s == 1, s[1:0]}, {13'h0000, lreq, bsrc});
			if (s == 1)
			begin
				ldone = 1'b1;
				@(negedge clk);
				ldone = 1'b0;
			end
		end
		chk("await after reset", 16'h0000, {15'h0000, oper});
		rd(ADDR_CKS1_HI);
		chk("reload-free report", 16'h1234, v);
		wr(ADDR_PROG, 16'hffff);
		wr(ADDR_PROG, 16'hffff);
		rd(ADDR_CKS1_HI);
		chk("dead mark", LOCK_MARK, v);
		gen_reset(BOOT_HOST_LOAD);
		chk("locked", 16'h0000, {13'h0000, lreq, oper, bsrc});
		give_verdict();
	end
endmodule
`default_nettype wire
